// file: hdl/sawax_ctrl.sv
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module sawax_ctrl import sawax_pkg::*; #(
  parameter int unsigned P_GATE_CYC = GATE_CYC_DEF,
  parameter int unsigned P_DWELL_CYC = REV_DWELL_CYC_DEF
) (
  input wire logic i_ref_clk, // 25 MHz clock
  input wire logic i_rst_b, // synchronous reset, low active
  input wire logic i_clk_en, // freezes all state while low
  input wire logic i_psel, // APB select
  input wire logic i_penable, // APB enable
  input wire logic i_pwrite, // APB direction
  input wire logic [7:0] i_paddr, // APB byte address
  input wire logic [31:0] i_pwdata, // APB write data
  output logic [31:0] o_prdata, // APB read data
  output logic o_pready, // APB ready
  output logic o_pslverr, // APB error on unmapped address
  input wire logic i_carriage_sync, // carriage at cut position, in sync
  input wire logic i_start_cmd, // saw start command pin
  input wire logic i_cut_done_cmd, // cut finished command pin
  input wire logic i_enc_a, // saw encoder track A
  input wire logic i_enc_b, // saw encoder track B
  output logic signed [15:0] o_speed_mv, // saw analogue setpoint in mV
  output logic o_cut_permitted_output, // cut permitted handshake
  output logic o_carriage_return, // one-cycle carriage return request
  output logic o_axis_active, // saw axis enabled
  output logic o_diag_free // second analogue output free
);

  sawax_st_t q;
  sawax_st_t d;

  logic setup;
  logic access;
  logic a_s;
  logic b_s;
  logic step;
  logic up;
  logic start_edge;
  logic done_edge;
  logic carr_edge;
  logic signed [31:0] acc;
  logic signed [31:0] scl;
  logic signed [31:0] bp1;
  logic signed [31:0] bp2;
  logic signed [31:0] bp3;
  logic signed [31:0] bp4;
  logic signed [15:0] tgt;
  logic [6:0] rt;
  logic [17:0] rlim;
  logic signed [32:0] err;
  logic signed [47:0] g48;
  logic signed [47:0] prod;
  logic signed [47:0] lim48;
  logic signed [15:0] corr;
  logic [32:0] dv_t;
  logic holding;
  logic off;

  function automatic logic signed [15:0] mv(input logic [31:0] r);
    mv = $signed({2'b00, r[13:0]});
    // Only bits 13:0 of the setting count; a value there above full scale is held at full scale.
    if (mv > 16'(FULL_SCALE_MV)) begin
      mv = 16'(FULL_SCALE_MV);
    end
  endfunction

  function automatic logic signed [31:0] lu(input logic [31:0] r);
    lu = $signed({12'h000, r[19:0]});
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= ADR_MEAS);
  endfunction

  function automatic logic [31:0] rd(input sawax_st_t s,
                                     input logic [7:0] a);
    rd = 32'h0000_0000;
    case (a)
      ADR_MODE: rd = s.cfg.mode;
      ADR_SCALE: rd = s.cfg.scale;
      ADR_GAIN: rd = s.cfg.gain;
      ADR_CLIM: rd = s.cfg.clim;
      ADR_FMAX: rd = s.cfg.fmax;
      ADR_RAMP: rd = s.cfg.ramp;
      ADR_SPD1: rd = s.cfg.spd1;
      ADR_POS1: rd = s.cfg.pos1;
      ADR_SPD2: rd = s.cfg.spd2;
      ADR_POS2: rd = s.cfg.pos2;
      ADR_SPD3: rd = s.cfg.spd3;
      ADR_POS3: rd = s.cfg.pos3;
      ADR_SPD4: rd = s.cfg.spd4;
      ADR_POS4: rd = s.cfg.pos4;
      ADR_RETSPD: rd = s.cfg.retspd;
      ADR_STATUS: begin
        rd[STAT_CUT_BIT] = s.cut_perm;
        rd[STAT_ACTIVE_BIT] = (s.cfg.mode != MODE_OFF);
        rd[STAT_STATE_LSB +: 3] = s.st;
      end
      ADR_POSITION: rd = s.pos;
      ADR_SETPOINT: rd = 32'(s.spd_out);
      ADR_MEAS: rd = s.meas;
      default: rd = 32'h0000_0000;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  // Zero wait states; a frozen block keeps the bus in its access phase.
  assign o_pready = i_psel & i_penable & i_clk_en;
  assign o_prdata = q.prdata;
  assign o_pslverr = q.pslverr & o_pready;
  assign o_speed_mv = q.spd_out;
  assign o_cut_permitted_output = q.cut_perm;
  assign o_carriage_return = q.carr_ret;
  assign o_axis_active = (q.cfg.mode != MODE_OFF);
  // R01: analogue output freed
  assign o_diag_free = (q.cfg.mode == MODE_OFF);

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    d = q;
    setup = i_psel & ~i_penable;
    access = i_psel & i_penable;
    a_s = q.sy_a[1];
    b_s = q.sy_b[1];
    // One track changed; the new A against the old B gives the direction.
    step = (a_s ^ q.sy_a[2]) != (b_s ^ q.sy_b[2]);
    up = a_s ^ q.sy_b[2];
    start_edge = q.sy_start[1] & ~q.sy_start[2];
    done_edge = q.sy_done[1] & ~q.sy_done[2];
    // Only a fresh rise of the carriage level starts a cycle.
    carr_edge = i_carriage_sync & ~q.carr_prev;
    off = (q.cfg.mode == MODE_OFF);
    scl = lu(q.cfg.scale);
    bp1 = lu(q.cfg.pos1);
    bp2 = lu(q.cfg.pos2);
    bp3 = lu(q.cfg.pos3);
    bp4 = lu(q.cfg.pos4);
    tgt = 16'sh0000;
    // A ramp time of zero would give no step period, so it counts as one: one mV each 100 us.
    rt = (q.cfg.ramp[6:0] == 7'h00) ? 7'h01 : q.cfg.ramp[6:0];
    rlim = 18'(rt) * RAMP_STEP_CYC;
    err = 33'sh0;
    g48 = $signed({34'h0, q.cfg.gain[13:0]});
    prod = 48'sh0;
    lim48 = $signed({34'h0, q.cfg.clim[13:0]});
    // The limit itself never reaches beyond full scale.
    if (lim48 > 48'(FULL_SCALE_MV)) begin
      lim48 = 48'(FULL_SCALE_MV);
    end
    corr = 16'sh0000;
    dv_t = 33'h0;
    holding = 1'b1;

    // Command and encoder pins pass two flops; the third stage only delays for edges.
    d.sy_start = {q.sy_start[1:0], i_start_cmd};
    d.sy_done = {q.sy_done[1:0], i_cut_done_cmd};
    d.sy_a = {q.sy_a[1:0], i_enc_a};
    d.sy_b = {q.sy_b[1:0], i_enc_b};
    d.carr_prev = i_carriage_sync;
    d.carr_ret = 1'b0;

    // Bus slave: read data and error are latched in the setup cycle.
    if (setup) begin
      d.prdata = rd(q, i_paddr);
      d.pslverr = ~mapped(i_paddr);
    end
    if (access && i_pwrite && !q.pslverr) begin
      case (i_paddr)
        ADR_MODE: d.cfg.mode = i_pwdata;
        ADR_SCALE: d.cfg.scale = i_pwdata;
        ADR_GAIN: d.cfg.gain = i_pwdata;
        ADR_CLIM: d.cfg.clim = i_pwdata;
        ADR_FMAX: d.cfg.fmax = i_pwdata;
        ADR_RAMP: d.cfg.ramp = i_pwdata;
        ADR_SPD1: d.cfg.spd1 = i_pwdata;
        ADR_POS1: d.cfg.pos1 = i_pwdata;
        ADR_SPD2: d.cfg.spd2 = i_pwdata;
        ADR_POS2: d.cfg.pos2 = i_pwdata;
        ADR_SPD3: d.cfg.spd3 = i_pwdata;
        ADR_POS3: d.cfg.pos3 = i_pwdata;
        ADR_SPD4: d.cfg.spd4 = i_pwdata;
        ADR_POS4: d.cfg.pos4 = i_pwdata;
        ADR_RETSPD: d.cfg.retspd = i_pwdata;
        default: d.cfg = q.cfg;
      endcase
    end

    // R09: thousand units per scale pulses
    acc = q.rem;
    if (step) begin
      acc = up ? acc + LU_PER_SCALE : acc - LU_PER_SCALE;
    end
    // R21: signed home-relative count
    if (scl != 32'sh0) begin
      if (acc >= scl) begin
        d.pos = q.pos + 32'sh1;
        acc = acc - scl;
      end else if (acc <= -scl) begin
        d.pos = q.pos - 32'sh1;
        acc = acc + scl;
      end
    end
    d.rem = acc;

    // R12: pulses per gate normalised to mV
    d.npulse = step ? q.npulse + 32'h1 : q.npulse;
    d.gate = q.gate + 32'h1;
    if (q.gate >= P_GATE_CYC - 1) begin
      d.gate = 32'h0;
      d.npulse = 32'h0;
      if (q.cfg.fmax == 32'h0) begin
        d.meas = 32'h0;
      end else begin
        // The count of the closing gate, this cycle's edge included.
        d.dv_num = 48'(q.npulse + 32'(step)) * NORM_NUM;
        d.dv_rem = 33'h0;
        d.dv_cnt = DIV_STEPS;
      end
    end else if (q.dv_cnt != 6'h00) begin
      dv_t = {q.dv_rem[31:0], q.dv_num[47]};
      d.dv_num = {q.dv_num[46:0], 1'b0};
      if (dv_t >= {1'b0, q.cfg.fmax}) begin
        dv_t = dv_t - {1'b0, q.cfg.fmax};
        d.dv_num[0] = 1'b1;
      end
      d.dv_rem = dv_t;
      d.dv_cnt = q.dv_cnt - 6'h01;
      if (q.dv_cnt == 6'h01) begin
        d.meas = (|d.dv_num[47:32]) ? 32'hFFFF_FFFF : d.dv_num[31:0];
      end
    end

    // Sequence of the stroke.
    unique case (q.st)
      ST_HOME: begin
        if (carr_edge && q.cfg.mode == MODE_AUTO) begin
          // R02: automatic stroke start
          d.st = ST_FWD;
        end else if (carr_edge && q.cfg.mode == MODE_HANDSHAKE) begin
          // R04: permit the cut
          d.cut_perm = 1'b1;
          d.st = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (q.cfg.mode != MODE_HANDSHAKE) begin
          d.cut_perm = 1'b0;
          d.st = ST_HOME;
        end else if (start_edge) begin
          // R05: start command begins stroke
          d.st = ST_FWD;
        end
      end
      ST_FWD: begin
        holding = 1'b0;
        // R14: first speed segment
        if (q.pos < bp1) begin
          tgt = mv(q.cfg.spd1);
        // R15: second speed past breakpoint one
        // R16: second speed segment
        end else if (q.pos < bp2) begin
          tgt = mv(q.cfg.spd2);
        // R17: third speed past breakpoint two
        end else if (q.pos < bp3) begin
          tgt = mv(q.cfg.spd3);
        // R20: fourth speed past breakpoint three
        end else begin
          tgt = mv(q.cfg.spd4);
        end
        // R18: reversal at breakpoint four
        if (q.pos >= bp4) begin
          d.st = ST_FSTOP;
        end
      end
      ST_FSTOP: begin
        holding = 1'b0;
        if (q.ramp == 16'sh0000) begin
          d.dwell = 32'h0;
          d.st = ST_RHOLD;
        end
      end
      ST_RHOLD: begin
        // The saw settles under the hold loop before it reverses.
        d.dwell = q.dwell + 32'h1;
        if (q.dwell >= P_DWELL_CYC - 1) begin
          d.st = ST_RET;
        end
      end
      ST_RET: begin
        holding = 1'b0;
        // R19: dedicated return speed
        tgt = -mv(q.cfg.retspd);
        if (q.pos <= 32'sh0) begin
          d.st = ST_RSTOP;
        end
      end
      ST_RSTOP: begin
        holding = 1'b0;
        if (q.ramp == 16'sh0000) begin
          if (q.cfg.mode == MODE_HANDSHAKE) begin
            // R06: drop permit at home
            d.cut_perm = 1'b0;
            d.st = ST_CUTW;
          end else begin
            // R03: automatic carriage return
            d.carr_ret = 1'b1;
            d.st = ST_HOME;
          end
        end
      end
      ST_CUTW: begin
        // A mode change away from the handshake returns on its own; a change to mode 0 goes home without the return pulse.
        if (q.cfg.mode != MODE_HANDSHAKE) begin
          d.carr_ret = 1'b1;
          d.st = ST_HOME;
        // R07: return only on command
        end else if (done_edge) begin
          d.carr_ret = 1'b1;
          d.st = ST_HOME;
        end
      end
    endcase

    // R13: one mV per ramp step
    d.rtick = q.rtick + 18'h1;
    if (q.rtick >= rlim - 18'h1) begin
      d.rtick = 18'h0;
      if (q.ramp < tgt) begin
        d.ramp = q.ramp + 16'sh1;
      end else if (q.ramp > tgt) begin
        d.ramp = q.ramp - 16'sh1;
      end
    end

    // R10: proportional hold correction
    err = (q.st == ST_RHOLD) ? 33'(bp4) - 33'(q.pos) : -33'(q.pos);
    prod = (g48 * 48'(err)) >>> GAIN_SHIFT;
    // R11: clamp output, error unclamped
    if (prod > lim48) begin
      corr = 16'(lim48);
    end else if (prod < -lim48) begin
      corr = 16'(-lim48);
    end else begin
      corr = 16'(prod);
    end

    // R08: open loop moving, hold at rest
    d.spd_out = holding ? corr : q.ramp;

    // R01: disabled axis stays idle
    if (off) begin
      d.st = ST_HOME;
      d.cut_perm = 1'b0;
      d.ramp = 16'sh0000;
      d.spd_out = 16'sh0000;
      d.carr_ret = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      q <= '0;
    end else if (i_clk_en) begin
      q <= d;
    end
  end

endmodule

// file: hdl/sawax_pkg.sv
// How it works
// R01: Mode 0 keeps saw axis inactive.
// R02: Mode 1 starts stroke on carriage sync.
// R03: Mode 1 returns carriage, ignores commands.
// R04: Mode 2 raises cut permitted on sync.
// R05: Mode 2 stroke waits for start command.
// R06: Mode 2 drops cut permitted at home.
// R07: Mode 2 carriage returns on cut finished.
// R08: Open loop moving, position hold resting.
// R09: Encoder counts scaled per 1000 units.
// R10: Hold correction is gain times error.
// R11: Correction clamped, error kept unclamped.
// R12: Full-speed frequency normalises measured speed.
// R13: Speed ramp slope from ramp time.
// R14: First speed from home to breakpoint one.
// R15: Breakpoint one switches to second speed.
// R16: Second speed between breakpoints one, two.
// R17: Breakpoint two switches to third speed.
// R18: Breakpoint four reverses stroke toward home.
// R19: Return uses dedicated return speed.
// R20: Breakpoint three switches to fourth speed.
// R21: Signed position counter, home is zero.
package sawax_pkg;

  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_KHZ = CLK_HZ / 1000;

  // Register byte addresses.
  localparam logic [7:0] ADR_MODE = 8'h00;
  localparam logic [7:0] ADR_SCALE = 8'h04;
  localparam logic [7:0] ADR_GAIN = 8'h08;
  localparam logic [7:0] ADR_CLIM = 8'h0C;
  localparam logic [7:0] ADR_FMAX = 8'h10;
  localparam logic [7:0] ADR_RAMP = 8'h14;
  localparam logic [7:0] ADR_RSVD = 8'h18;
  localparam logic [7:0] ADR_SPD1 = 8'h1C;
  localparam logic [7:0] ADR_POS1 = 8'h20;
  localparam logic [7:0] ADR_SPD2 = 8'h24;
  localparam logic [7:0] ADR_POS2 = 8'h28;
  localparam logic [7:0] ADR_SPD3 = 8'h2C;
  localparam logic [7:0] ADR_POS3 = 8'h30;
  localparam logic [7:0] ADR_SPD4 = 8'h34;
  localparam logic [7:0] ADR_POS4 = 8'h38;
  localparam logic [7:0] ADR_RETSPD = 8'h3C;
  localparam logic [7:0] ADR_STATUS = 8'h40;
  localparam logic [7:0] ADR_POSITION = 8'h44;
  localparam logic [7:0] ADR_SETPOINT = 8'h48;
  localparam logic [7:0] ADR_MEAS = 8'h4C;

  // Operating modes.
  localparam logic [31:0] MODE_OFF = 32'h0000_0000;
  localparam logic [31:0] MODE_AUTO = 32'h0000_0001;
  localparam logic [31:0] MODE_HANDSHAKE = 32'h0000_0002;

  // Field layout of the status register.
  localparam int STAT_CUT_BIT = 0;
  localparam int STAT_ACTIVE_BIT = 1;
  localparam int STAT_STATE_LSB = 4;

  // Scaling and timing.
  localparam logic signed [31:0] LU_PER_SCALE = 32'sh0000_03E8;
  localparam int FULL_SCALE_MV = 10000;
  localparam int RAMP_STEP_US = 100;
  localparam logic [17:0] RAMP_STEP_CYC =
    18'(RAMP_STEP_US * (CLK_HZ / 1_000_000));
  localparam int GATE_MS = 100;
  localparam int GATE_PER_S = 1000 / GATE_MS;
  localparam int unsigned GATE_CYC_DEF = GATE_MS * CLK_KHZ;
  localparam logic [47:0] NORM_NUM = 48'(FULL_SCALE_MV * GATE_PER_S);
  localparam int REV_DWELL_MS = 20;
  localparam int unsigned REV_DWELL_CYC_DEF = REV_DWELL_MS * CLK_KHZ;
  localparam int GAIN_SHIFT = 10;
  localparam logic [5:0] DIV_STEPS = 6'h30;

  typedef struct packed {
    logic [31:0] mode;
    logic [31:0] scale;
    logic [31:0] gain;
    logic [31:0] clim;
    logic [31:0] fmax;
    logic [31:0] ramp;
    logic [31:0] spd1;
    logic [31:0] pos1;
    logic [31:0] spd2;
    logic [31:0] pos2;
    logic [31:0] spd3;
    logic [31:0] pos3;
    logic [31:0] spd4;
    logic [31:0] pos4;
    logic [31:0] retspd;
  } sawax_cfg_t;

  typedef enum logic [2:0] {
    ST_HOME, ST_ARMED, ST_FWD, ST_FSTOP, ST_RHOLD, ST_RET, ST_RSTOP, ST_CUTW
  } sawax_state_t;

  typedef struct packed {
    sawax_cfg_t cfg;
    logic [31:0] prdata;
    logic pslverr;
    logic [2:0] sy_start;
    logic [2:0] sy_done;
    logic [2:0] sy_a;
    logic [2:0] sy_b;
    logic carr_prev;
    logic signed [31:0] pos;
    logic signed [31:0] rem;
    logic signed [15:0] ramp;
    logic signed [15:0] spd_out;
    logic [17:0] rtick;
    sawax_state_t st;
    logic cut_perm;
    logic carr_ret;
    logic [31:0] dwell;
    logic [31:0] gate;
    logic [31:0] npulse;
    logic [31:0] meas;
    logic [32:0] dv_rem;
    logic [47:0] dv_num;
    logic [5:0] dv_cnt;
  } sawax_st_t;

endpackage

// file: test/sawax_ctrl_props.sv
`timescale 1ns/100ps
module sawax_ctrl_props (
  input wire logic i_ref_clk, // clock
  input wire logic i_rst_b, // reset, low active
  input wire logic i_clk_en, // clock enable
  input wire logic i_psel, // APB select
  input wire logic i_penable, // APB enable
  input wire logic i_carriage_sync, // carriage in sync
  input wire logic i_start_cmd, // saw start pin
  input wire logic o_pready, // APB ready
  input wire logic o_pslverr, // APB error
  input wire logic signed [15:0] o_speed_mv, // setpoint
  input wire logic o_cut_permitted_output, // cut permitted
  input wire logic o_carriage_return, // return pulse
  input wire logic o_axis_active, // axis enabled
  input wire logic o_diag_free // output free
);
  logic start_seen_q;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_b);
  // Remembers a start command given while the cut is permitted.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b || !o_cut_permitted_output) begin
      start_seen_q <= 1'b0;
    end else if (i_start_cmd) begin
      start_seen_q <= 1'b1;
    end
  end
  ready_zero_a:
    assert property (i_psel && i_penable && i_clk_en |-> o_pready)
    else $error("pready not given in access cycle");
  idle_quiet_a:
    assert property (!i_psel |-> !o_pready && !o_pslverr)
    else $error("ready or error outside a transfer");
  axis_diag_a:
    assert property (o_axis_active != o_diag_free)
    else $error("diag free does not mirror axis off");
  off_quiet_a:
    assert property (!o_axis_active && $past(!o_axis_active) |->
      o_speed_mv == 16'sh0000 && !o_cut_permitted_output)
    else $error("inactive axis still drives");
  perm_rise_a:
    assert property ($rose(o_cut_permitted_output) |->
      $past(i_carriage_sync) && o_axis_active)
    else $error("permit rose without carriage sync");
  wait_start_a:
    assert property (o_cut_permitted_output && o_speed_mv != 16'sh0000
      |-> start_seen_q)
    else $error("saw moved before start command");
  perm_fall_a:
    assert property ($fell(o_cut_permitted_output) && o_axis_active |->
      o_speed_mv == 16'sh0000)
    else $error("permit dropped while saw moving");
  ret_pulse_a:
    assert property (o_carriage_return |=>
      !o_carriage_return && !o_cut_permitted_output)
    else $error("carriage return pulse too long");
  ret_home_a:
    assert property (o_carriage_return |-> !o_cut_permitted_output)
    else $error("carriage return while cut permitted");
  speed_range_a:
    assert property (o_speed_mv <= 16'sh2710 && o_speed_mv >= -16'sh2710)
    else $error("setpoint beyond full scale");
endmodule

// file: test/sawax_mc_model.sv
`timescale 1ns/100ps
module sawax_mc_model #(
  parameter int P_DLY = 300
) (
  input wire logic i_ref_clk, // clock
  input wire logic i_rst_b, // reset, low active
  input wire logic signed [15:0] i_speed_mv, // saw setpoint
  input wire logic i_permit, // cut permitted
  output logic o_enc_a, // encoder track A
  output logic o_enc_b, // encoder track B
  output logic o_start, // saw start command
  output logic o_done // cut finished command
);
  int acc;
  int cs;
  int cd;
  logic [1:0] ph;
  logic perm_q;
  logic dir_q;
  assign o_enc_a = ph[0] ^ ph[1];
  assign o_enc_b = ph[1];
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      acc <= 0;
      cs <= 0;
      cd <= 0;
      ph <= 2'h0;
      perm_q <= 1'b0;
      dir_q <= 1'b1;
      o_start <= 1'b0;
      o_done <= 1'b0;
    end else begin
      perm_q <= i_permit;
      // At standstill the last direction of travel still applies.
      if (i_speed_mv != 16'sh0000) begin
        dir_q <= (i_speed_mv > 0);
      end
      // Saw travels one encoder edge per 1000 mV-cycles of setpoint.
      if (acc >= 1000) begin
        acc <= acc - 1000;
        ph <= ((i_speed_mv > 0) || (i_speed_mv == 16'sh0000 && dir_q)) ?
          ph + 2'h1 : ph - 2'h1;
      end else if (i_speed_mv < 0) begin
        acc <= acc - int'(i_speed_mv);
      end else begin
        acc <= acc + int'(i_speed_mv);
      end
      cs <= (i_permit && !perm_q) ? P_DLY + 8 : (cs > 0 ? cs - 1 : 0);
      cd <= (!i_permit && perm_q) ? P_DLY + 8 : (cd > 0 ? cd - 1 : 0);
      o_start <= cs inside {[1:8]};
      o_done <= cd inside {[1:8]};
    end
  end
endmodule

// file: test/testbench.sv
`timescale 1ns/100ps
module testbench import sawax_pkg::*;;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic sync = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, st, dn, ea, eb, perm, cret, act, diag;
  logic signed [15:0] spd;
  int failures = 0;
  int n_compared = 0;
  always #20 clk = ~clk;
  sawax_ctrl #(.P_GATE_CYC(200), .P_DWELL_CYC(20)) dut_u (
    .i_ref_clk(clk), .i_rst_b(rst_b), .i_clk_en(1'b1), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_carriage_sync(sync), .i_start_cmd(st), .i_cut_done_cmd(dn),
    .i_enc_a(ea), .i_enc_b(eb), .o_speed_mv(spd),
    .o_cut_permitted_output(perm), .o_carriage_return(cret),
    .o_axis_active(act), .o_diag_free(diag));
  sawax_mc_model #(.P_DLY(300)) mc_u (
    .i_ref_clk(clk), .i_rst_b(rst_b), .i_speed_mv(spd), .i_permit(perm),
    .o_enc_a(ea), .o_enc_b(eb), .o_start(st), .o_done(dn));
  ////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      test_done();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic stroke(output logic signed [15:0] pk, mn,
    output int tf, tc, output logic ps);
    pk = 0;
    mn = 0;
    tf = 0;
    tc = 0;
    ps = 1'b0;
    for (int t = 1; t < 60000 && tc == 0; t++) begin
      @(posedge clk);
      if (spd > pk) pk = spd;
      if (spd < mn) mn = spd;
      if (perm) ps = 1'b1;
      if (ps && !perm && tf == 0) tf = t;
      if (cret) tc = t;
    end
    if (tc == 0) begin
      failures++;
      test_done();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    check("axis_active", 32'(act), 32'h0);
    check("diag_free", 32'(diag), 32'h1);
    apb(1'b0, ADR_MODE, 32'h0, r, e);
    check("mode reset", r, MODE_OFF);
    wr(ADR_RSVD, 32'hFFFF_FFFF);
    apb(1'b0, ADR_RSVD, 32'h0, r, e);
    check("reserved", r, 32'h0);
    apb(1'b0, 8'h50, 32'h0, r, e);
    check("unmapped", 32'(e), 32'h1);
  endtask
  task automatic t_cfg();
    logic [7:0] ad [12] = '{ADR_SCALE, ADR_RAMP, ADR_FMAX, ADR_SPD1,
      ADR_POS1, ADR_SPD2, ADR_POS2, ADR_SPD3, ADR_POS3, ADR_SPD4,
      ADR_POS4, ADR_RETSPD};
    logic [31:0] dv [12] = '{32'h3E8, 32'h1, 32'h3E8, 32'h1, 32'h1,
      32'h2, 32'h3, 32'h3, 32'h10, 32'h1, 32'h12, 32'h2};
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 12; i++) begin
      wr(ad[i], dv[i]);
      apb(1'b0, ad[i], 32'h0, r, e);
      check("config", r, dv[i]);
    end
  endtask
  task automatic t_mode2();
    logic signed [15:0] pk, mn;
    int tf, tc;
    logic ps;
    logic [31:0] r;
    logic e;
    wr(ADR_MODE, MODE_HANDSHAKE);
    sync <= 1'b1;
    cyc(5);
    check("permit", 32'(perm), 32'h1);
    apb(1'b0, ADR_STATUS, 32'h0, r, e);
    check("armed", 32'(r[6:4]), 32'h1);
    stroke(pk, mn, tf, tc, ps);
    check("peak", 32'(pk), 32'h3);
    check("return", 32'(mn), 32'hFFFF_FFFE);
    check("done wait", 32'(tc - tf > 300), 32'h1);
    sync <= 1'b0;
  endtask
  task automatic t_hold();
    logic [31:0] r;
    logic e;
    longint p;
    longint x;
    wr(ADR_CLIM, 32'h1);
    apb(1'b0, ADR_POSITION, 32'h0, r, e);
    p = longint'($signed(r));
    wr(ADR_GAIN, 32'h3E8);
    apb(1'b0, ADR_SETPOINT, 32'h0, r, e);
    x = (-p * 1000) >>> GAIN_SHIFT;
    x = (x > 1) ? 1 : ((x < -1) ? -1 : x);
    check("hold corr", r, 32'(x));
    wr(ADR_GAIN, 32'h0);
  endtask
  task automatic t_mode1();
    logic signed [15:0] pk, mn;
    int tf, tc;
    logic ps;
    wr(ADR_MODE, MODE_AUTO);
    sync <= 1'b1;
    stroke(pk, mn, tf, tc, ps);
    check("auto peak", 32'(pk), 32'h3);
    check("auto permit", 32'(ps), 32'h0);
    sync <= 1'b0;
  endtask
  task automatic t_abort();
    wr(ADR_MODE, MODE_AUTO);
    sync <= 1'b1;
    cyc(3000);
    check("moving", 32'(spd > 0), 32'h1);
    wr(ADR_MODE, MODE_OFF);
    cyc(2);
    check("off speed", 32'(spd), 32'h0);
    check("off diag", 32'(diag), 32'h1);
    sync <= 1'b0;
  endtask
  initial begin
    cyc(2);
    rst_b <= 1'b1;
    t_regs();
    t_cfg();
    t_mode2();
    t_hold();
    t_mode1();
    t_abort();
    test_done();
  end
endmodule
bind sawax_ctrl sawax_ctrl_props chk_u (
  .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_clk_en(i_clk_en),
  .i_psel(i_psel), .i_penable(i_penable),
  .i_carriage_sync(i_carriage_sync), .i_start_cmd(i_start_cmd),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_speed_mv(o_speed_mv),
  .o_cut_permitted_output(o_cut_permitted_output),
  .o_carriage_return(o_carriage_return), .o_axis_active(o_axis_active),
  .o_diag_free(o_diag_free));
